/* File: hw/wsr_regs.sv */
// module: watchdog status registers, lockable output set-up and event interrupt
`timescale 1ns/1ps
module wsr_regs
    import wsr_pkg::*;
#(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 32
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              cfg_locked,
    input  wire wsr_wdog_s         wdog_in,
    output wsr_setup_s             setup_out,
    output logic                   irq
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (ADDR_W < 10) begin : g_bad_addr
        $error("wsr_regs: ADDR_W must be at least 10");
    end
    if (DATA_W < 8) begin : g_bad_data
        $error("wsr_regs: DATA_W must be at least 8");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        wsr_wdog_s             wdog;
        logic                  locked;
        logic [7:0]            setup_a;
        logic [5:0]            setup_b;
        logic [IRQ_N-1:0]      irq_status;
        logic [IRQ_N-1:0]      irq_enable;
        logic [7:0]            rdata;
    } wsr_state_s;

    localparam wsr_wdog_s WDOG_RST = '{
        func_pass_counter:             RST_PASS_COUNTER,
        func_response_counter:         RST_RESP_COUNTER,
        func_challenge_value:          RST_CHALLENGE,
        total_error_counter:           RST_TOTAL_ERROR,
        window_service_seen:           1'b0,
        secure_shutoff_timer_started:  1'b0,
        window_powerdown_counter:      RST_PD_COUNTER,
        reset_event_counter:           RST_PD_COUNTER,
        total_error_powerdown_counter: RST_PD_COUNTER,
        func_powerdown_counter:        RST_PD_COUNTER,
        heartbeat_prescaler_sample:    RST_HB_PRESCALER,
        heartbeat_timer_sample:        RST_HB_TIMER
    };

    localparam wsr_state_s STATE_RST = '{
        wdog:       WDOG_RST,
        locked:     1'b0,
        setup_a:    RST_SETUP_GROUP_A,
        setup_b:    RST_SETUP_GROUP_B,
        irq_status: '0,
        irq_enable: '0,
        rdata:      8'h00
    };

    wsr_state_s state_q;
    wsr_state_s state_d;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic            aligned;
    logic [7:0]      idx;
    logic [ADDR_W:0] addr_high;

    // misaligned or out-of-range addresses fall through as unmapped;
    // the shift keeps the range check legal when ADDR_W is exactly 10
    assign addr_high = {1'b0, reg_addr} >> 10;
    assign aligned   = (reg_addr[1:0] == 2'b00) && (addr_high == '0);
    assign idx     = reg_addr[9:2];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic             wr_a;
        logic             wr_b;
        logic [IRQ_N-1:0] events;
        logic [IRQ_N-1:0] clear;
        wr_a    = 1'b0;
        wr_b    = 1'b0;
        events  = '0;
        clear   = '0;
        state_d = state_q;

        // status is a registered copy of the watchdog side; no bus write reaches it
        state_d.wdog   = wdog_in;
        state_d.locked = cfg_locked;

        wr_a = reg_wr && aligned && (idx == IDX_SETUP_GROUP_A);
        wr_b = reg_wr && aligned && (idx == IDX_SETUP_GROUP_B);

        if (wr_a && !state_q.locked) begin
            state_d.setup_a = reg_wdata[7:0];
        end
        if (wr_b && !state_q.locked) begin
            state_d.setup_b = reg_wdata[SETUP_B_USED-1:0];
        end

        // events: refused write, rising service / shut-off flags, error count change
        events[IRQ_LOCKED_WRITE] = (wr_a || wr_b) && state_q.locked;
        events[IRQ_SERVICE]      = wdog_in.window_service_seen
                                   && !state_q.wdog.window_service_seen;
        events[IRQ_SHUTOFF]      = wdog_in.secure_shutoff_timer_started
                                   && !state_q.wdog.secure_shutoff_timer_started;
        events[IRQ_ERROR_CHANGE] = wdog_in.total_error_counter
                                   != state_q.wdog.total_error_counter;

        if (reg_wr && aligned && (idx == IDX_IRQ_CLEAR)) begin
            clear = reg_wdata[IRQ_N-1:0];
        end
        if (reg_wr && aligned && (idx == IDX_IRQ_ENABLE)) begin
            state_d.irq_enable = reg_wdata[IRQ_N-1:0];
        end
        // a new event in the clearing cycle survives the clear
        state_d.irq_status = (state_q.irq_status & ~clear) | events;

        // read data stands only in the cycle after the strobe
        state_d.rdata = 8'h00;
        if (reg_rd && aligned) begin
            unique case (idx)
                IDX_LOCK_STATUS: begin
                    state_d.rdata[LOCK_BIT] = state_q.locked;
                end
                IDX_FUNC_PASS: begin
                    state_d.rdata = {2'b00, state_q.wdog.func_pass_counter};
                end
                IDX_FUNC_QRESP: begin
                    state_d.rdata = {2'b00, state_q.wdog.func_response_counter,
                                     state_q.wdog.func_challenge_value};
                end
                IDX_TOTAL_ERROR: begin
                    state_d.rdata = {2'b00, state_q.wdog.total_error_counter};
                end
                IDX_WDOG_SERVICE: begin
                    state_d.rdata[SERVICE_BIT] = state_q.wdog.window_service_seen;
                    state_d.rdata[SHUTOFF_BIT] =
                        state_q.wdog.secure_shutoff_timer_started;
                    state_d.rdata[5:0] = {state_q.wdog.window_powerdown_counter,
                                          state_q.wdog.reset_event_counter};
                end
                IDX_WDOG_POWERDOWN: begin
                    state_d.rdata = {2'b00,
                                     state_q.wdog.total_error_powerdown_counter,
                                     state_q.wdog.func_powerdown_counter};
                end
                IDX_HB_PRESCALER: begin
                    state_d.rdata = {4'h0, state_q.wdog.heartbeat_prescaler_sample};
                end
                IDX_HB_TIMER: begin
                    state_d.rdata = {1'b0, state_q.wdog.heartbeat_timer_sample};
                end
                IDX_SETUP_GROUP_A: begin
                    state_d.rdata = state_q.setup_a;
                end
                IDX_SETUP_GROUP_B: begin
                    state_d.rdata = {2'b00, state_q.setup_b};
                end
                IDX_IRQ_STATUS: begin
                    state_d.rdata[IRQ_N-1:0] = state_q.irq_status;
                end
                IDX_IRQ_ENABLE: begin
                    state_d.rdata[IRQ_N-1:0] = state_q.irq_enable;
                end
                default: begin
                    state_d.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= STATE_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign reg_rdata = {{(DATA_W-8){1'b0}}, state_q.rdata};
    assign irq       = |(state_q.irq_status & state_q.irq_enable);

    // group a holds open-load above overcurrent per output, outputs 1..4
    for (genvar n = 0; n < 4; n++) begin : g_group_a
        assign setup_out.openload_cfg[n]    = state_q.setup_a[2*n+1];
        assign setup_out.overcurrent_cfg[n] = state_q.setup_a[2*n];
    end
    for (genvar n = 0; n < 3; n++) begin : g_group_b
        assign setup_out.openload_cfg[n+4]    = state_q.setup_b[2*n+1];
        assign setup_out.overcurrent_cfg[n+4] = state_q.setup_b[2*n];
    end

endmodule : wsr_regs

/* File: hw/wsr_pkg.sv */
// package: map, field layout, reset values and carriers of the watchdog status / output set-up bank
package wsr_pkg;

    // ------------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_LOCK_STATUS    = 8'h35;
    localparam logic [7:0] IDX_FUNC_PASS      = 8'h37;
    localparam logic [7:0] IDX_FUNC_QRESP     = 8'h38;
    localparam logic [7:0] IDX_TOTAL_ERROR    = 8'h39;
    localparam logic [7:0] IDX_WDOG_SERVICE   = 8'h3a;
    localparam logic [7:0] IDX_WDOG_POWERDOWN = 8'h3b;
    localparam logic [7:0] IDX_HB_PRESCALER   = 8'h3c;
    localparam logic [7:0] IDX_HB_TIMER       = 8'h3d;
    localparam logic [7:0] IDX_SETUP_GROUP_A  = 8'h40;
    localparam logic [7:0] IDX_SETUP_GROUP_B  = 8'h41;
    localparam logic [7:0] IDX_IRQ_STATUS     = 8'h50;
    localparam logic [7:0] IDX_IRQ_CLEAR      = 8'h51;
    localparam logic [7:0] IDX_IRQ_ENABLE     = 8'h52;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int         LOCK_BIT            = 7;
    localparam int         SERVICE_BIT         = 7;
    localparam int         SHUTOFF_BIT         = 6;
    localparam int         SETUP_B_USED        = 6;
    localparam logic [5:0] RST_PASS_COUNTER    = 6'h30;
    localparam logic [1:0] RST_RESP_COUNTER    = 2'h3;
    localparam logic [3:0] RST_CHALLENGE       = 4'h0;
    localparam logic [5:0] RST_TOTAL_ERROR     = 6'h30;
    localparam logic [2:0] RST_PD_COUNTER      = 3'h0;
    localparam logic [3:0] RST_HB_PRESCALER    = 4'h0;
    localparam logic [6:0] RST_HB_TIMER        = 7'h00;
    localparam logic [7:0] RST_SETUP_GROUP_A   = 8'hff;
    localparam logic [5:0] RST_SETUP_GROUP_B   = 6'h3f;
    localparam int         IRQ_N               = 4;
    localparam int         IRQ_LOCKED_WRITE    = 0;
    localparam int         IRQ_SERVICE         = 1;
    localparam int         IRQ_SHUTOFF         = 2;
    localparam int         IRQ_ERROR_CHANGE    = 3;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [5:0] func_pass_counter;
        logic [1:0] func_response_counter;
        logic [3:0] func_challenge_value;
        logic [5:0] total_error_counter;
        logic       window_service_seen;
        logic       secure_shutoff_timer_started;
        logic [2:0] window_powerdown_counter;
        logic [2:0] reset_event_counter;
        logic [2:0] total_error_powerdown_counter;
        logic [2:0] func_powerdown_counter;
        logic [3:0] heartbeat_prescaler_sample;
        logic [6:0] heartbeat_timer_sample;
    } wsr_wdog_s;

    // index 0 is output 1; bit set means full diagnosis / switch off
    typedef struct packed {
        logic [6:0] openload_cfg;
        logic [6:0] overcurrent_cfg;
    } wsr_setup_s;

endpackage : wsr_pkg

/* File: tb/wsr_regs_sva.sv */
// checker: port assertions of the watchdog status and output set-up bank
`timescale 1ns/1ps
module wsr_regs_sva
    import wsr_pkg::*;
#(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 32
) (
    input wire logic              sys_clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              cfg_locked,
    input wire wsr_wdog_s         wdog_in,
    input wire wsr_setup_s        setup_out,
    input wire logic              irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------------
    // helpers: write data one cycle back, watchdog inputs two cycles back
    // ------------------------------------------------------------------
    wire logic wr_a = reg_wr && reg_addr == 10'h100;
    wire logic wr_b = reg_wr && reg_addr == 10'h104;
    logic [7:0] wd_q;
    wsr_wdog_s  w1_q;
    wsr_wdog_s  w2_q;
    always_ff @(posedge sys_clk) begin
        wd_q <= reg_wdata[7:0];
        w1_q <= wdog_in;
        w2_q <= w1_q;
    end
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    chk_rd_upper_zero: assert property (reg_rdata[DATA_W-1:8] == '0)
        else $error("read data upper bits set");
    chk_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data without read");
    chk_lock_keep_a: assert property (wr_a && $past(cfg_locked) && !$past(rst)
        |=> $stable(setup_out)) else $error("locked group a write took effect");
    chk_lock_keep_b: assert property (wr_b && $past(cfg_locked) && !$past(rst)
        |=> $stable(setup_out)) else $error("locked group b write took effect");
    chk_map_grp_a: assert property (wr_a && !$past(cfg_locked) && !$past(rst) |=>
        setup_out.openload_cfg[3:0] == {wd_q[7], wd_q[5], wd_q[3], wd_q[1]} &&
        setup_out.overcurrent_cfg[3:0] == {wd_q[6], wd_q[4], wd_q[2], wd_q[0]})
        else $error("group a field placement wrong");
    chk_map_grp_b: assert property (wr_b && !$past(cfg_locked) && !$past(rst) |=>
        setup_out.openload_cfg[6:4] == {wd_q[5], wd_q[3], wd_q[1]} &&
        setup_out.overcurrent_cfg[6:4] == {wd_q[4], wd_q[2], wd_q[0]})
        else $error("group b field placement wrong");
    chk_pass_lag: assert property (reg_rd && reg_addr == 10'h0dc && !$past(rst) |=>
        reg_rdata[7:0] == {2'h0, w2_q.func_pass_counter}) else $error("pass counter read wrong");
    chk_service_lag: assert property (reg_rd && reg_addr == 10'h0e8 && !$past(rst) |=>
        reg_rdata[7:0] == {w2_q.window_service_seen, w2_q.secure_shutoff_timer_started,
        w2_q.window_powerdown_counter, w2_q.reset_event_counter}) else $error("service read wrong");
    chk_lock_flag: assert property (reg_rd && reg_addr == 10'h0d4 && !$past(rst) |=>
        reg_rdata[7:0] == {$past(cfg_locked, 2), 7'h00}) else $error("lock flag read wrong");
endmodule : wsr_regs_sva

bind wsr_regs wsr_regs_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (.sys_clk(sys_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cfg_locked(cfg_locked), .wdog_in(wdog_in),
    .setup_out(setup_out), .irq(irq));

/* File: tb/tb.sv */
// testbench: register tests of the watchdog status and output set-up bank
`timescale 1ns/1ps
module tb
    import wsr_pkg::*;
;
    logic        sys_clk, rst, reg_wr, reg_rd, cfg_locked, irq;
    logic [9:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    wsr_wdog_s   wdog_in;
    wsr_setup_s  setup_out;
    int          err_total, checks_done;
    // status addresses first, set-up groups last
    logic [9:0]  a_tab [10] = '{10'h0d4, 10'h0dc, 10'h0e0, 10'h0e4, 10'h0e8, 10'h0ec,
                                10'h0f0, 10'h0f4, 10'h100, 10'h104};
    logic [7:0]  r_tab [10] = '{8'h00, 8'h30, 8'h30, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00,
                                8'hff, 8'h3f};
    logic [7:0]  l_tab [10] = '{8'h00, 8'h2a, 8'h19, 8'h15, 8'haa, 8'h31, 8'h0c, 8'h5a,
                                8'h00, 8'h00};
    wsr_regs u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_locked(cfg_locked),
        .wdog_in(wdog_in), .setup_out(setup_out), .irq(irq));
    // ------------------------------------------------------------------
    // bus tasks and comparison
    // ------------------------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= {24'h0, d};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        cmp($sformatf("read %h", a), {24'h0, e}, reg_rdata);
    endtask : rd
    // read at the first edge after release sees the reset copy, not the live input
    task automatic reset_read(input logic [9:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        cmp($sformatf("reset %h", a), {24'h0, e}, reg_rdata);
    endtask : reset_read
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    // ------------------------------------------------------------------
    // clock, watchdog, tests
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        err_total++;
        conclude();
    end
    initial begin
        {rst, reg_wr, reg_rd, cfg_locked, reg_addr, reg_wdata} = '0;
        rst = 1'b1;
        wdog_in = '1;
        err_total = 0;
        checks_done = 0;
        for (int i = 0; i < 10; i++) reset_read(a_tab[i], r_tab[i]);
        cmp("setup", 32'h3fff, {18'h0, setup_out});
        $display("test reset values done");
        @(posedge sys_clk);
        wdog_in <= {6'h2a, 2'h1, 4'h9, 6'h15, 2'b10, 3'h5, 3'h2, 3'h6, 3'h1, 4'hc, 7'h5a};
        repeat (2) @(posedge sys_clk);
        for (int i = 1; i < 8; i++) begin
            wr(a_tab[i], 8'hff);
            rd(a_tab[i], l_tab[i]);
        end
        rd(10'h3fc, 8'h00);
        $display("test status fields done");
        wr(10'h100, 8'h5a);
        wr(10'h104, 8'he6);
        rd(10'h100, 8'h5a);
        rd(10'h104, 8'h26);
        cmp("setup", {18'h0, 7'h53, 7'h2c}, {18'h0, setup_out});
        $display("test set-up fields done");
        wr(10'h144, 8'h0f);
        wr(10'h148, 8'h01);
        @(posedge sys_clk);
        cfg_locked <= 1'b1;
        repeat (2) @(posedge sys_clk);
        wr(10'h100, 8'h00);
        wr(10'h104, 8'h00);
        cmp("setup", {18'h0, 7'h53, 7'h2c}, {18'h0, setup_out});
        rd(10'h104, 8'h26);
        rd(10'h0d4, 8'h80);
        cmp("irq", 32'h1, {31'h0, irq});
        rd(10'h140, 8'h01);
        wr(10'h148, 8'h00);
        cmp("irq", 32'h0, {31'h0, irq});
        wr(10'h148, 8'h01);
        cmp("irq", 32'h1, {31'h0, irq});
        wr(10'h144, 8'h01);
        cmp("irq", 32'h0, {31'h0, irq});
        @(posedge sys_clk);
        cfg_locked <= 1'b0;
        repeat (2) @(posedge sys_clk);
        wr(10'h100, 8'h00);
        wr(10'h104, 8'h00);
        cmp("setup", 32'h0, {18'h0, setup_out});
        $display("test lock and mask done");
        wr(10'h148, 8'h0f);
        @(posedge sys_clk);
        wdog_in.secure_shutoff_timer_started <= 1'b1;
        wdog_in.total_error_counter <= 6'h16;
        repeat (3) @(posedge sys_clk);
        rd(10'h140, 8'h0c);
        cmp("irq", 32'h1, {31'h0, irq});
        wr(10'h144, 8'h0f);
        rd(10'h140, 8'h00);
        rd(10'h148, 8'h0f);
        // a service edge in the very cycle of its clear must survive the clear
        @(posedge sys_clk);
        wdog_in.window_service_seen <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= 10'h144;
        reg_wdata <= 32'h2;
        wdog_in.window_service_seen <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
        rd(10'h140, 8'h02);
        cmp("irq", 32'h1, {31'h0, irq});
        $display("test events done");
        conclude();
    end
endmodule : tb
